//--- hw/async_serial_uart_core.sv
/*
 * Top of the serial core: register file on the CPU bus, transmit framer,
 * line synchroniser, receive bookkeeping and interrupt request.
 * Assumes single-cycle CPU strokes on clk and asynchronous serial pins.
 */
`timescale 1ns/10ps
`default_nettype none
module async_serial_uart_core
    import uart_core_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // CPU bus
    input wire bus_req_t cpu_req,
    output logic [7:0] bus_rdata,
    // Serial pins
    input wire logic serial_input_line,
    input wire logic external_baud_clock_input,
    output logic serial_output_line,
    output logic serial_output_enable,
    output logic serial_input_select,
    // Status toward the system
    output logic rx_complete_irq,
    output logic infrared_mode
);
    mode_t mode_q, mode_d;
    logic [7:0] baud_q, baud_d;
    logic [7:0] hold_q, hold_d;
    logic [2:0] status_q, status_d;
    logic unread_q, unread_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic rx_meta_q, rx_sync_q;
    logic half_tick, rx_done;
    rx_result_t rx_res;
    logic wr_data, rd_data;

    frame_state_t tx_q, tx_d;
    logic [7:0] tx_shift_q, tx_shift_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic tx_phase_q, tx_phase_d;
    logic tx_stop_q, tx_stop_d;
    logic tx_par_q, tx_par_d;
    logic line_q, line_d;
    logic oe_q, ie_q, ir_q;
    logic advance;

    baud_divider u_baud (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(mode_q.transmit_enable_bit | mode_q.receive_enable_bit),
        .ctrl(baud_q),
        .ext_clk_pin(external_baud_clock_input),
        .half_tick(half_tick)
    );

    rx_framer u_rx (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode(mode_q),
        .half_tick(half_tick),
        .rxd(rx_sync_q),
        .done(rx_done),
        .result(rx_res)
    );

    // Register file; reads are registered so bus_rdata comes from a flop.
    always_comb begin
        mode_d = mode_q;
        baud_d = baud_q;
        rdata_d = rdata_q;
        wr_data = cpu_req.wr && (cpu_req.addr == DATA_ADDR);
        rd_data = cpu_req.rd && (cpu_req.addr == DATA_ADDR);
        if (cpu_req.wr) begin
            if (cpu_req.addr == MODE_ADDR) begin
                mode_d = mode_t'(cpu_req.wdata);
            end else if (cpu_req.addr == BAUD_ADDR) begin
                baud_d = {1'b0, cpu_req.wdata[6:0]};
            end
        end
        if (cpu_req.rd) begin
            if (cpu_req.addr == MODE_ADDR) begin
                rdata_d = mode_q;
            end else if (cpu_req.addr == STATUS_ADDR) begin
                rdata_d = {5'h00, status_q};
            end else if (cpu_req.addr == BAUD_ADDR) begin
                rdata_d = baud_q;
            end else if (cpu_req.addr == DATA_ADDR) begin
                rdata_d = hold_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Receive bookkeeping. A completion in the same cycle as a buffer read
    // wins, so the new character is never mistaken for already read.
    always_comb begin
        hold_d = hold_q;
        status_d = status_q;
        unread_d = unread_q;
        irq_d = 1'b0;
        if (rd_data) begin
            unread_d = 1'b0;
        end
        if (rx_done) begin
            hold_d = mode_q.character_length_bit ? rx_res.data
                                                : {1'b0, rx_res.data[6:0]};
            status_d[PE_BIT] = rx_res.perr;
            status_d[FE_BIT] = rx_res.ferr;
            status_d[OVE_BIT] = unread_q;
            unread_d = 1'b1;
            irq_d = !(mode_q.error_interrupt_suppress &&
                      (rx_res.perr || rx_res.ferr || unread_q));
        end
    end

    // Transmit framer; one bit lasts two half-bit ticks.
    always_comb begin
        tx_d = tx_q;
        tx_shift_d = tx_shift_q;
        tx_bit_d = tx_bit_q;
        tx_phase_d = tx_phase_q;
        tx_stop_d = tx_stop_q;
        tx_par_d = tx_par_q;
        advance = half_tick & tx_phase_q;
        if (half_tick) begin
            tx_phase_d = ~tx_phase_q;
        end
        case (tx_q)
            FR_IDLE: begin
                if (wr_data && mode_q.transmit_enable_bit) begin
                    tx_d = FR_START;
                    tx_phase_d = 1'b0;
                    tx_shift_d = mode_q.character_length_bit ? cpu_req.wdata
                        : {1'b0, cpu_req.wdata[6:0]};
                    tx_par_d = parity_of(tx_shift_d, mode_q.parity);
                end
            end
            FR_START: begin
                if (advance) begin
                    tx_d = FR_DATA;
                    tx_bit_d = '0;
                end
            end
            FR_DATA: begin
                if (advance) begin
                    tx_shift_d = {1'b0, tx_shift_q[7:1]};
                    tx_bit_d = tx_bit_q + 1'b1;
                    if (tx_bit_q == {2'b11, mode_q.character_length_bit}) begin
                        tx_d = (mode_q.parity == PAR_NONE) ? FR_STOP
                                                           : FR_PARITY;
                        tx_stop_d = 1'b0;
                    end
                end
            end
            FR_PARITY: begin
                if (advance) begin
                    tx_d = FR_STOP;
                    tx_stop_d = 1'b0;
                end
            end
            FR_STOP: begin
                if (advance) begin
                    if (mode_q.stop_length_bit && !tx_stop_q) begin
                        tx_stop_d = 1'b1;
                    end else begin
                        tx_d = FR_IDLE;
                    end
                end
            end
            default: tx_d = FR_IDLE;
        endcase
        if (!mode_q.transmit_enable_bit) begin
            tx_d = FR_IDLE;
        end
        case (tx_q)
            FR_START: line_d = 1'b0;
            FR_DATA: line_d = tx_shift_q[0];
            FR_PARITY: line_d = tx_par_q;
            default: line_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= mode_t'(MODE_RESET);
            baud_q <= BAUD_RESET;
            hold_q <= HOLD_RESET;
            status_q <= STATUS_RESET[2:0];
            unread_q <= 1'b0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            tx_q <= FR_IDLE;
            tx_shift_q <= '0;
            tx_bit_q <= '0;
            tx_phase_q <= 1'b0;
            tx_stop_q <= 1'b0;
            tx_par_q <= 1'b0;
            line_q <= 1'b1;
            oe_q <= 1'b0;
            ie_q <= 1'b0;
            ir_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            baud_q <= baud_d;
            hold_q <= hold_d;
            status_q <= status_d;
            unread_q <= unread_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            rx_meta_q <= serial_input_line;
            rx_sync_q <= rx_meta_q;
            tx_q <= tx_d;
            tx_shift_q <= tx_shift_d;
            tx_bit_q <= tx_bit_d;
            tx_phase_q <= tx_phase_d;
            tx_stop_q <= tx_stop_d;
            tx_par_q <= tx_par_d;
            line_q <= line_d;
            oe_q <= mode_q.transmit_enable_bit;
            ie_q <= mode_q.receive_enable_bit;
            ir_q <= mode_q.infrared_mode_select;
        end
    end

    assign bus_rdata = rdata_q;
    assign serial_output_line = line_q;
    assign serial_output_enable = oe_q;
    assign serial_input_select = ie_q;
    assign rx_complete_irq = irq_q;
    assign infrared_mode = ir_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence tx_kick;
        wr_data && mode_q.transmit_enable_bit && tx_q == FR_IDLE;
    endsequence

    sequence rx_finish;
        rx_done ##1 1'b1;
    endsequence

    AST_START_BIT: assert property (tx_kick |-> ##2 !serial_output_line)
        else $error("transmit write did not drive a start bit");
    AST_LOAD_HOLD: assert property (rx_done && mode_q.character_length_bit
        |=> hold_q == $past(rx_res.data))
        else $error("received character not loaded into holding buffer");
    AST_SEVEN_BIT: assert property (rx_done && !mode_q.character_length_bit
        |=> !hold_q[7])
        else $error("seven-bit character left bit 7 set");
    AST_STATUS_HIGH: assert property (cpu_req.rd && cpu_req.addr == STATUS_ADDR
        |=> bus_rdata[7:3] == 5'h00 && bus_rdata[2:0] == $past(status_q))
        else $error("status read returned wrong bits");
    AST_OVERRUN: assert property (rx_done && unread_q
        |=> status_q[OVE_BIT] && unread_q)
        else $error("overrun not flagged on unread buffer");
    AST_FLAGS: assert property (rx_finish |-> status_q[PE_BIT:FE_BIT] ==
        {$past(rx_res.perr), $past(rx_res.ferr)})
        else $error("error flags do not match received character");
    AST_IRQ_SUPPRESS: assert property (rx_done && mode_q.error_interrupt_suppress
        && (rx_res.perr || rx_res.ferr || unread_q) |=> !rx_complete_irq)
        else $error("interrupt raised for errored character");
    AST_IRQ_RAISE: assert property (rx_done && !mode_q.error_interrupt_suppress
        |=> rx_complete_irq ##1 !rx_complete_irq)
        else $error("receive-complete interrupt not a single pulse");
    AST_STOPPED: assert property (!mode_q.transmit_enable_bit
        |=> !serial_output_enable ##1 serial_output_line)
        else $error("stopped transmitter still owns or drives the line");
endmodule
`default_nettype wire

//--- hw/uart_core_pkg.sv
/*
 * Constants, field layouts, states and carriers of the serial core.
 * Assumes a single 20 MHz clock and an active-high asynchronous reset.
 */
// What this block does
// - A fully received character moves from the receive shifter into the holding buffer.
// - In seven-bit mode the holding buffer gets bits 0 to 6, bit 7 zero.
// - The holding buffer is read-only, eight bits wide, and resets to all ones.
// - The data address writes the transmit shifter and reads the holding buffer.
// - A read-only error status register reports receive errors and resets to zero.
// - Status bits 7 to 3 read zero; bit 2 parity, bit 1 framing, bit 0 overrun.
// - Parity flag sets when received parity disagrees with the configured parity.
// - Framing flag sets when the first stop bit is low; only one is checked.
// - Overrun flags a completion while the buffer is still unread; it holds until the next completion.
// - Transmit adds start, optional parity and configured stop bits per the mode register.
// - The mode register is read/write, eight bits, reset to zero (stopped).
// - Mode bits 7 and 6 enable transmit and receive and hand over the lines.
// - Parity field: none, zero sent and unchecked, odd, or even.
// - Character length bit picks seven or eight data bits; seven sends bits 0 to 6.
// - Stop length bit picks one or two transmitted stop bits.
// - Error-interrupt bit set suppresses receive-complete interrupt for errored characters.
// - Mode bit 0 selects infrared transfer; enables still come from bits 7 and 6.
// - Baud divider register is eight bits, writable except bit 7 (always written zero), reset to zero.
// - Writing the transmit shifter starts transmission of that character.
// - Baud field n picks external clock or clock divided by 2^n; k divides 16+k.
package uart_core_pkg;

    localparam logic [15:0] MODE_ADDR = 16'hffa0;
    localparam logic [15:0] STATUS_ADDR = 16'hffa1;
    localparam logic [15:0] BAUD_ADDR = 16'hffa2;
    localparam logic [15:0] DATA_ADDR = 16'hff18;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'hff;

    localparam int PE_BIT = 2;
    localparam int FE_BIT = 1;
    localparam int OVE_BIT = 0;
    localparam int SRC_LSB = 4;
    localparam logic [4:0] DIV_BASE = 5'h0f;
    localparam int PRESCALE_W = 7;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD = 2'b10,
        PAR_EVEN = 2'b11
    } parity_t;

    // Field order matches the mode register bit for bit, 7 down to 0.
    typedef struct packed {
        logic transmit_enable_bit;
        logic receive_enable_bit;
        parity_t parity;
        logic character_length_bit;
        logic stop_length_bit;
        logic error_interrupt_suppress;
        logic infrared_mode_select;
    } mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic perr;
        logic ferr;
    } rx_result_t;

    typedef enum logic [4:0] {
        FR_IDLE = 5'b00001,
        FR_START = 5'b00010,
        FR_DATA = 5'b00100,
        FR_PARITY = 5'b01000,
        FR_STOP = 5'b10000
    } frame_state_t;

    function automatic logic parity_of(input logic [7:0] d, input parity_t p);
        logic r;
        r = 1'b0;
        if (p == PAR_ODD) begin
            r = ~^d;
        end else if (p == PAR_EVEN) begin
            r = ^d;
        end
        return r;
    endfunction

endpackage

//--- hw/baud_divider.sv
/*
 * Baud generator: prescaler or external clock, then a 16+k divider.
 * Assumes the external clock pin is asynchronous and much slower than clk.
 */
`timescale 1ns/10ps
`default_nettype none
module baud_divider
    import uart_core_pkg::*;
#(
    parameter int PRE_W = PRESCALE_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    input wire logic [7:0] ctrl,
    input wire logic ext_clk_pin,
    // Half-bit tick
    output logic half_tick
);
    if (PRE_W < 7) begin : g_chk
        $error("baud_divider needs PRE_W of at least 7");
    end

    logic ext_meta_q, ext_sync_q, ext_prev_q;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [4:0] div_q, div_d;
    logic tick_q, tick_d;
    logic [2:0] n;
    logic [PRE_W-1:0] mask;
    logic src_tick;

    // The divider output is twice the baud rate, so each bit is two ticks.
    always_comb begin
        n = ctrl[SRC_LSB +: 3];
        mask = PRE_W'((8'h01 << n) - 8'h01);
        src_tick = (n == 3'h0) ? (ext_sync_q & ~ext_prev_q)
                               : (&(pre_q | ~mask));
        pre_d = run ? pre_q + 1'b1 : '0;
        div_d = div_q;
        tick_d = 1'b0;
        if (!run) begin
            div_d = '0;
        end else if (src_tick) begin
            if (div_q >= DIV_BASE + {1'b0, ctrl[3:0]}) begin
                div_d = '0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
            pre_q <= '0;
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_clk_pin;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
            pre_q <= pre_d;
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    assign half_tick = tick_q;
endmodule
`default_nettype wire

//--- hw/rx_framer.sv
/*
 * Receive shifter: start detection, centre sampling, parity and stop check.
 * Assumes rxd is already synchronised to clk and half_tick comes from
 * the baud divider.
 */
`timescale 1ns/10ps
`default_nettype none
module rx_framer
    import uart_core_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire mode_t mode,
    input wire logic half_tick,
    input wire logic rxd,
    // Result
    output logic done,
    output rx_result_t result
);
    frame_state_t st_q, st_d;
    logic prev_q, phase_q, phase_d, done_q, done_d;
    logic [2:0] bit_q, bit_d;
    rx_result_t res_q, res_d;
    logic [7:0] shift_q, shift_d;
    logic centre;

    always_comb begin
        st_d = st_q;
        phase_d = phase_q;
        bit_d = bit_q;
        shift_d = shift_q;
        res_d = res_q;
        done_d = 1'b0;
        centre = half_tick & phase_q;
        if (half_tick) begin
            phase_d = ~phase_q;
        end
        case (st_q)
            FR_IDLE: begin
                if (mode.receive_enable_bit && prev_q && !rxd) begin
                    st_d = FR_START;
                    phase_d = 1'b1;
                    shift_d = '0;
                end
            end
            FR_START: begin
                if (centre) begin
                    st_d = rxd ? FR_IDLE : FR_DATA;
                    bit_d = '0;
                end
            end
            FR_DATA: begin
                if (centre) begin
                    shift_d[bit_q] = rxd;
                    bit_d = bit_q + 1'b1;
                    if (bit_q == {2'b11, mode.character_length_bit}) begin
                        st_d = (mode.parity == PAR_NONE) ? FR_STOP : FR_PARITY;
                    end
                end
            end
            FR_PARITY: begin
                if (centre) begin
                    res_d.perr = mode.parity[1] &&
                        (rxd != parity_of(shift_q, mode.parity));
                    st_d = FR_STOP;
                end
            end
            FR_STOP: begin
                if (centre) begin
                    if (mode.parity == PAR_NONE || mode.parity == PAR_ZERO) begin
                        res_d.perr = 1'b0;
                    end
                    res_d.ferr = !rxd;
                    res_d.data = shift_q;
                    done_d = 1'b1;
                    st_d = FR_IDLE;
                end
            end
            default: st_d = FR_IDLE;
        endcase
        if (!mode.receive_enable_bit) begin
            st_d = FR_IDLE;
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= FR_IDLE;
            prev_q <= 1'b1;
            phase_q <= 1'b0;
            bit_q <= '0;
            shift_q <= '0;
            res_q <= '0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            prev_q <= rxd;
            phase_q <= phase_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            res_q <= res_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
    assign result = res_q;
endmodule
`default_nettype wire

//--- bench/serial_remote.sv
/*
 * Remote serial transceiver on the far side of the core's data lines.
 * Assumes a bit lasts BIT_CLKS cycles of clk on both sides.
 */
`timescale 1ns/10ps
`default_nettype none
module serial_remote #(
    parameter int BIT_CLKS = 64
) (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic tx_line,
    output logic rx_line
);
    initial rx_line = 1'b1;

    // Shifts a prepared frame out LSB first; unused tail bits stay high.
    task automatic send(input logic [11:0] f);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            rx_line <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
    endtask

    // The start bit may be up to half a bit short, so sampling begins a
    // quarter bit after the falling edge and stays inside every bit.
    task automatic recv(output logic [11:0] f);
        @(negedge tx_line);
        repeat (BIT_CLKS / 4) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            f[i] = tx_line;
            if (i < 11) repeat (BIT_CLKS) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

//--- bench/async_serial_uart_core_tb.sv
/*
 * Self-checking bench for the serial core: registers, transmit frames,
 * receive frames, receive errors and overrun.
 * Assumes baud 10H, so one bit is 64 clocks at 20 MHz.
 */
`timescale 1ns/10ps
`default_nettype none
module async_serial_uart_core_tb
    import uart_core_pkg::*;
();
    localparam int BIT = 64;
    logic clk;
    logic sys_rst;
    bus_req_t cpu_req;
    logic [7:0] bus_rdata;
    logic rxl;
    logic txl;
    logic tx_oe;
    logic rx_sel;
    logic irq;
    logic ir;
    logic [7:0] md;
    logic [11:0] fr;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int ic = 0;
    logic ext_pin = 1'b0;
    logic ext_on = 1'b0;

    async_serial_uart_core dut_u (
        .clk(clk), .sys_rst(sys_rst), .cpu_req(cpu_req),
        .bus_rdata(bus_rdata), .serial_input_line(rxl),
        .external_baud_clock_input(ext_pin),
        .serial_output_line(txl), .serial_output_enable(tx_oe),
        .serial_input_select(rx_sel), .rx_complete_irq(irq),
        .infrared_mode(ir)
    );

    serial_remote #(.BIT_CLKS(BIT)) remote_u (
        .clk(clk), .tx_line(txl), .rx_line(rxl)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Frames run about 800 cycles each, so 40000 leaves ample margin.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) ic <= ic + 1;
        if (ext_on) ext_pin <= ~ext_pin;
        if (cyc == 40000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_req <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        cpu_req.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        cpu_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        cpu_req.rd <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask

    // Whole frame from start bit onward, padded with idle high bits.
    function automatic logic [11:0] mk(input logic [7:0] d,
            input logic [7:0] m, input logic bad, input logic fe);
        int n;
        logic [11:0] f;
        n = m[3] ? 8 : 7;
        f = 12'hffe;
        for (int i = 0; i < n; i++) f[1 + i] = d[i];
        if (m[5:4] != 2'b00) begin
            f[1 + n] = m[5] & (^(d & {m[3], 7'h7f}) ^ ~m[4]) ^ bad;
            n++;
        end
        f[1 + n] = ~fe;
        return f;
    endfunction

    task automatic set_mode(input logic [7:0] m);
        md = m;
        wr(MODE_ADDR, 8'h00);
        wr(MODE_ADDR, m);
        rchk(MODE_ADDR, m);
    endtask

    task automatic t_reset();
        #1 chk({txl, tx_oe, rx_sel, ir}, 4'b1000);
        rchk(MODE_ADDR, 8'h00);
        rchk(STATUS_ADDR, 8'h00);
        rchk(BAUD_ADDR, 8'h00);
        rchk(DATA_ADDR, 8'hff);
        wr(DATA_ADDR, 8'h12);
        wr(STATUS_ADDR, 8'hff);
        rchk(DATA_ADDR, 8'hff);
        rchk(STATUS_ADDR, 8'h00);
        rchk(16'hff00, 8'h00);
        wr(BAUD_ADDR, 8'h10);
        rchk(BAUD_ADDR, 8'h10);
    endtask

    task automatic t_modes();
        logic [7:0] m;
        for (int i = 0; i < 4; i++) begin
            m = {i[1:0], 6'h01};
            set_mode(m);
            repeat (2) @(posedge clk);
            #1 chk({tx_oe, rx_sel, ir}, {m[7:6], 1'b1});
        end
    endtask

    task automatic t_tx(input logic [7:0] d);
        wr(DATA_ADDR, d);
        remote_u.recv(fr);
        chk(fr, mk(d, md, 1'b0, 1'b0));
    endtask

    // A write during the second stop bit must be refused as busy.
    task automatic t_stop2();
        logic lo;
        wr(DATA_ADDR, 8'h00);
        lo = 1'b0;
        repeat (150) @(posedge clk) lo |= ~txl;
        chk(lo, 1'b0);
    endtask

    task automatic rx_case(input logic [7:0] d, input logic bad,
            input logic fe, input logic [7:0] st, input int n_irq);
        int c0;
        c0 = ic;
        remote_u.send(mk(d, md, bad, fe));
        chk(ic - c0, n_irq);
        rchk(STATUS_ADDR, st);
        rchk(DATA_ADDR, d & {md[3], 7'h7f});
    endtask

    task automatic t_overrun();
        remote_u.send(mk(8'h11, md, 1'b0, 1'b0));
        remote_u.send(mk(8'h22, md, 1'b0, 1'b0));
        rchk(STATUS_ADDR, 8'h01);
        remote_u.send(mk(8'h33, md, 1'b0, 1'b0));
        rchk(STATUS_ADDR, 8'h01);
        rchk(DATA_ADDR, 8'h33);
        rx_case(8'h44, 1'b0, 1'b0, 8'h00, 1);
    endtask

    // The pin toggles every clock, so n=0 gives the same 64-clock bit.
    task automatic t_ext();
        wr(MODE_ADDR, 8'h00);
        wr(BAUD_ADDR, 8'h00);
        rchk(BAUD_ADDR, 8'h00);
        ext_on = 1'b1;
        set_mode(8'he8);
        t_tx(8'h3c);
        rx_case(8'h3c, 1'b1, 1'b0, 8'h04, 1);
    endtask

    initial begin
        sys_rst = 1'b1;
        cpu_req = '0;
        md = 8'h00;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_modes();
        set_mode(8'hfc);
        t_tx(8'ha5);
        t_stop2();
        rx_case(8'h5a, 1'b0, 1'b0, 8'h00, 1);
        rx_case(8'h5a, 1'b1, 1'b0, 8'h04, 1);
        rx_case(8'h5a, 1'b0, 1'b1, 8'h02, 1);
        set_mode(8'hc2);
        t_tx(8'hc3);
        rx_case(8'hfe, 1'b0, 1'b0, 8'h00, 1);
        rx_case(8'h7e, 1'b0, 1'b1, 8'h02, 0);
        set_mode(8'hd8);
        t_tx(8'h81);
        rx_case(8'h81, 1'b1, 1'b0, 8'h00, 1);
        set_mode(8'hc8);
        t_overrun();
        t_ext();
        give_verdict();
    end
endmodule
`default_nettype wire
